// File: bench/bmrx_framer_props.sv
// Concurrent checks on the ports of the block message receive framer.
`include "bmrx_consts.svh"

module bmrx_framer_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_bit,
  input wire logic rx_bit_valid,
  input wire logic [`BMRX_CHAR_W-1:0] blk_char_data,
  input wire logic blk_char_valid,
  input wire logic blk_char_is_sel,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] nb;
  logic [6:0] dc;
  logic ss;
  logic mk;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Bit count since reset, data count since selection and mask state, so rules can be judged at the ports.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nb <= '0;
      dc <= '0;
      ss <= 1'b0;
      mk <= 1'b0;
    end else begin
      if (rx_bit_valid && nb != 7'h7f) nb <= nb + 7'h01;
      if (blk_char_valid) begin
        ss <= ss | blk_char_is_sel;
        dc <= blk_char_is_sel ? 7'h00 : dc + 7'h01;
      end
      if (psel && penable && pwrite && paddr == 12'h00c) mk <= |pwdata[6:0];
    end
  end

  sequence s_rd;
    psel && penable && !pwrite;
  endsequence

  // One hunted fill, two confirming fills, an opening and a selection come before any stored character.
  property p_no_early;
    blk_char_valid |-> nb >= 7'd40;
  endproperty
  a_no_early: assert property (p_no_early) else $error("block char before framing");
  property p_confirm;
    blk_char_valid |-> nb >= 7'd40 && nb != 7'd0;
  endproperty
  a_confirm: assert property (p_confirm) else $error("block char before logical frame");
  property p_first_sel;
    blk_char_valid |-> blk_char_is_sel || ss;
  endproperty
  a_first_sel: assert property (p_first_sel) else $error("data char before selection");
  property p_sel_pulse;
    blk_char_is_sel |-> blk_char_valid;
  endproperty
  a_sel_pulse: assert property (p_sel_pulse) else $error("selection mark without valid");
  property p_data_len;
    blk_char_valid && !blk_char_is_sel |-> dc < 7'd80;
  endproperty
  a_data_len: assert property (p_data_len) else $error("more than 80 data chars");
  property p_err;
    psel && penable |-> pslverr == (paddr > 12'h01c || paddr[1:0] != 2'b00);
  endproperty
  a_err: assert property (p_err) else $error("slave error wrong");
  property p_zero_rd;
    s_rd ##0 (paddr == 12'h000 || pslverr) |-> prdata == 32'h0000_0000;
  endproperty
  a_zero_rd: assert property (p_zero_rd) else $error("control or unmapped read not zero");
  property p_code1;
    s_rd ##0 paddr == 12'h01c |-> prdata[31:24] == 8'h00;
  endproperty
  a_code1: assert property (p_code1) else $error("unused code byte not zero");
  property p_irq;
    !mk |-> !irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt with all events masked");
endmodule : bmrx_framer_props

bind bmrx_framer bmrx_framer_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .blk_char_data(blk_char_data),
  .blk_char_valid(blk_char_valid), .blk_char_is_sel(blk_char_is_sel), .irq(irq));

// File: bench/bmrx_framer_tb_top.sv
// Self-checking testbench for the block message receive framer.
`include "bmrx_consts.svh"

module bmrx_framer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] st = `BMRX_OFF_STATUS;
  localparam logic [11:0] iq = `BMRX_OFF_IRQ_STAT;
  localparam logic [11:0] fd = `BMRX_OFF_FIELDS;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, send, slow, rx_bit, rx_bit_valid, busy;
  logic blk_char_valid, blk_char_is_sel, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] blk_char_data, ch, par, r;
  logic [15:0] seed = 16'hff16;
  logic [31:0] rq[$];
  logic [8:0] cq[$];
  int err_count = 0;
  int comparisons = 0;

  bmrx_framer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid), .blk_char_data(blk_char_data), .blk_char_valid(blk_char_valid),
    .blk_char_is_sel(blk_char_is_sel), .irq(irq));
  bmrx_line_model u_line (.pclk(pclk), .presetn(presetn), .send(send), .slow(slow), .ch(ch),
    .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .busy(busy));

  // Free-running clock.
  always #5 pclk = ~pclk;

  function automatic logic [7:0] rnd();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed[7:0];
  endfunction : rnd

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic test_done();
    if (err_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done

  // One APB transfer; the request stands until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  // Hands one character to the line model, then lets the receive pipeline settle.
  task automatic snd(input logic [7:0] c);
    @(posedge pclk);
    r = rnd();
    send <= 1'b1;
    ch <= c;
    slow <= r[0];
    @(posedge pclk);
    send <= 1'b0;
    @(negedge pclk);
    while (busy) @(negedge pclk);
    repeat (8) @(posedge pclk);
  endtask : snd

  task automatic frm();
    repeat (3) snd(`BMRX_RST_FILL);
  endtask : frm

  // Results are compared in order against the notes left by the drivers.
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) chk("prdata", rq.pop_front(), prdata);
    if (blk_char_valid) chk("blk_char", {23'b0, cq.pop_front()}, {23'b0, blk_char_is_sel, blk_char_data});
  end

  // Watchdog well beyond the few thousand cycles the sequence needs.
  initial begin
    repeat (60000) @(posedge pclk);
    err_count++;
    test_done();
  end

  initial begin
    {presetn, psel, penable, pwrite, send, slow, paddr, pwdata, ch} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(`BMRX_OFF_CODE0, 32'h0203_0116);
    rd(`BMRX_OFF_CODE1, 32'h0006_5417);
    rd(`BMRX_OFF_IRQ_MASK, 32'h0000_0000);
    apb(1'b1, 12'h020, 32'hffff_ffff);
    rd(12'h020, 32'h0000_0000);
    snd(8'h00);
    snd(8'h00);
    rd(st, 32'h0000_0000);
    snd(`BMRX_RST_FILL);
    rd(st, 32'h0000_0001);
    snd(8'h81);
    rd(st, 32'h0000_0000);
    frm();
    rd(st, 32'h0000_0003);
    rd(iq, 32'h0000_0003);
    rd(iq, 32'h0000_0000);
    apb(1'b1, `BMRX_OFF_IRQ_MASK, 32'h0000_0004);
    snd(`BMRX_RST_BOPEN);
    rd(st, 32'h0000_0013);
    snd(`BMRX_RST_FILL);
    rd(st, 32'h0000_0003);
    repeat (3) snd(rnd() | 8'h80);
    rd(st, 32'h0000_0000);
    frm();
    rd(iq, 32'h0000_0003);
    chk("irq", 32'h0000_0000, {31'b0, irq});
    snd(`BMRX_RST_MOPEN);
    rd(st, 32'h0000_000f);
    chk("irq", 32'h0000_0001, {31'b0, irq});
    cq.push_back({1'b1, `BMRX_RST_TAPE_SELECT_VARIANT});
    snd(`BMRX_RST_TAPE_SELECT_VARIANT);
    par = 8'h00;
    for (int i = 0; i < 80; i++) begin
      r = rnd() | 8'h80;
      par ^= r;
      cq.push_back({1'b0, r});
      snd(r);
    end
    rd(fd, 32'h0050_0005);
    snd(`BMRX_RST_FILL);
    snd(`BMRX_RST_MCLOSE);
    snd(par);
    rd(st, 32'h0000_0003);
    rd(`BMRX_OFF_PARITY, {16'h0000, par, par});
    rd(iq, 32'h0000_000c);
    snd(`BMRX_RST_MOPEN);
    cq.push_back({1'b1, 8'h41});
    snd(8'h41);
    snd(`BMRX_RST_BOPEN);
    rd(st, 32'h0000_0004);
    frm();
    rd(st, 32'h0000_0007);
    snd(`BMRX_RST_BOPEN);
    rd(st, 32'h0000_000f);
    rd(fd, 32'h0000_0002);
    apb(1'b1, `BMRX_OFF_CTRL, 32'h0000_0001);
    rd(st, 32'h0000_0004);
    test_done();
  end
endmodule : bmrx_framer_tb_top

// File: bench/bmrx_line_model.sv
// Remote transmitter model that shifts characters onto the serial line.
module bmrx_line_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic send,
  input wire logic slow,
  input wire logic [7:0] ch,
  output logic rx_bit,
  output logic rx_bit_valid,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  logic [3:0] n;
  logic [1:0] dv;

  // Bits go out LSB first; between bits the line toggles so a stale value can never pass as data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh <= '0;
      n <= '0;
      dv <= '0;
      rx_bit <= 1'b0;
      rx_bit_valid <= 1'b0;
    end else begin
      rx_bit_valid <= 1'b0;
      if (n == 4'h0) begin
        rx_bit <= ~rx_bit;
        if (send) begin
          sh <= ch;
          n <= 4'h8;
        end
      end else if (dv != 2'b00) begin
        dv <= dv - 2'b01;
        rx_bit <= ~rx_bit;
      end else begin
        rx_bit <= sh[0];
        rx_bit_valid <= 1'b1;
        sh <= sh >> 1;
        n <= n - 4'h1;
        dv <= slow ? 2'b11 : 2'b01;
      end
    end
  end

  assign busy = (n != 4'h0);
endmodule : bmrx_line_model

// File: design/bmrx_consts.svh
// Offsets, field positions, reset values and counts for the block message receive framer.
`ifndef BMRX_CONSTS_SVH
`define BMRX_CONSTS_SVH

// Character and queue geometry.
`define BMRX_CHAR_W 8
`define BMRX_FIFO_AW 4
`define BMRX_FIFO_DEPTH 16

// Framing counts.
`define BMRX_CONFIRM_FILLS 2'd2
`define BMRX_BAD_RUN 2'd3
`define BMRX_DATA_LEN 7'd80

// Register byte offsets.
`define BMRX_OFF_CTRL 12'h000
`define BMRX_OFF_STATUS 12'h004
`define BMRX_OFF_IRQ_STAT 12'h008
`define BMRX_OFF_IRQ_MASK 12'h00c
`define BMRX_OFF_FIELDS 12'h010
`define BMRX_OFF_PARITY 12'h014
`define BMRX_OFF_CODE0 12'h018
`define BMRX_OFF_CODE1 12'h01c

// Control register fields.
`define BMRX_CTRL_REHUNT 0

// Status register fields.
`define BMRX_ST_HW_FRAME 0
`define BMRX_ST_LOG_FRAME 1
`define BMRX_ST_MSG 2
`define BMRX_ST_DATA 3

// Interrupt event bits.
`define BMRX_IRQ_W 7
`define BMRX_EV_LOGICAL 0
`define BMRX_EV_LOST 1
`define BMRX_EV_BLOCK_START 2
`define BMRX_EV_CHECK_OK 3
`define BMRX_EV_CHECK_ERR 4
`define BMRX_EV_ANSWER 5
`define BMRX_EV_OVERFLOW 6

// Starting and ending control field bits.
`define BMRX_SF_MSG_OPEN 0
`define BMRX_SF_BLK_OPEN 1
`define BMRX_SF_TAPE_SEL 2
`define BMRX_EF_BLK_CLOSE 0
`define BMRX_EF_MSG_CLOSE 1

// Character code reset values, all arbitrary defaults for software to overwrite.
`define BMRX_RST_FILL 8'h16
`define BMRX_RST_MOPEN 8'h01
`define BMRX_RST_MCLOSE 8'h03
`define BMRX_RST_BOPEN 8'h02
`define BMRX_RST_BCLOSE 8'h17
`define BMRX_RST_TAPE_SELECT_VARIANT 8'h54
`define BMRX_RST_ANSWER 8'h06

`endif

// File: design/bmrx_fifo.sv
// Receive character queue with registered read data.
`include "bmrx_consts.svh"

module bmrx_fifo (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic flush,
  input wire logic wr_en,
  input wire logic [`BMRX_CHAR_W-1:0] wr_data,
  input wire logic rd_en,
  output logic [`BMRX_CHAR_W-1:0] rd_data,
  output logic rd_valid,
  output logic empty,
  output logic full
);

  logic [`BMRX_CHAR_W-1:0] mem [`BMRX_FIFO_DEPTH];
  logic [`BMRX_FIFO_AW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [`BMRX_FIFO_AW:0] cnt_reg, cnt_next;
  logic [`BMRX_CHAR_W-1:0] rdat_reg, rdat_next;
  logic rval_reg, rval_next;
  logic do_wr, do_rd;

  assign empty = (cnt_reg == '0);
  assign full = (cnt_reg == (`BMRX_FIFO_AW+1)'(`BMRX_FIFO_DEPTH));
  assign do_wr = wr_en && !full && !flush;
  assign do_rd = rd_en && !empty && !flush;

  // Pointer and count update; a flush also kills a read still in flight.
  always_comb begin
    wptr_next = do_wr ? wptr_reg + (`BMRX_FIFO_AW)'(1) : wptr_reg;
    rptr_next = do_rd ? rptr_reg + (`BMRX_FIFO_AW)'(1) : rptr_reg;
    cnt_next = cnt_reg;
    if (do_wr && !do_rd) begin
      cnt_next = cnt_reg + (`BMRX_FIFO_AW+1)'(1);
    end else if (do_rd && !do_wr) begin
      cnt_next = cnt_reg - (`BMRX_FIFO_AW+1)'(1);
    end
    rdat_next = do_rd ? mem[rptr_reg] : rdat_reg;
    rval_next = do_rd;
    if (flush) begin
      wptr_next = '0;
      rptr_next = '0;
      cnt_next = '0;
    end
  end

  // Storage array carries no reset, only its pointers, count, read data and read valid flag do.
  always_ff @(posedge pclk) begin
    if (do_wr) begin
      mem[wptr_reg] <= wr_data;
    end
  end

  // Queue state registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
      rdat_reg <= '0;
      rval_reg <= 1'b0;
    end else begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      cnt_reg <= cnt_next;
      rdat_reg <= rdat_next;
      rval_reg <= rval_next;
    end
  end

  assign rd_data = rdat_reg;
  assign rd_valid = rval_reg;

endmodule : bmrx_fifo

// File: design/bmrx_framer.sv
// Receive framer top: character queue, framing confirmation, message and data state tracking.
// Functional notes
// - Line unit forwards nothing until a line fill character is recognised.
// - Framed characters go through the receive queue, consumed first-in first-out.
// - Two more consecutive line fills are needed before logical framing.
// - Clearing the framing lock restarts bit hunting at any time.
// - Non-fill during confirmation or wrong framing character in data state restarts framing.
// - Non-message from startup, and from verified check after message-close.
// - Message state spans open to end; data state spans one block.
// - Legal framing characters depend on the combined message and data states.
// - Start-of-block enters data state; end-of-block leaves it, possibly message too.
// - Message-open only outside message; block-open only in message, non-data.
// - Three unbroken bad characters in non-data state drop framing.
// - After reframing data state is clear; message state is kept.
// - Start-of-block clears parity and control fields, then marks the start type.
// - Character after start: answer code first, else selection, tape variant flagged.
// - Data characters are summed, counted and buffered; after 80 await termination.
// - Character after a close is the check, compared with computed parity.
// - Block-close returns to non-data; message-close to non-message once its check verifies.
`include "bmrx_consts.svh"

module bmrx_framer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_bit,
  input wire logic rx_bit_valid,
  output logic [`BMRX_CHAR_W-1:0] blk_char_data,
  output logic blk_char_valid,
  output logic blk_char_is_sel,
  output logic irq
);

  localparam int CW = `BMRX_CHAR_W;

  bmrx_pkg::bmrx_state_t state_reg, state_next;
  logic msg_reg, msg_next;
  logic [1:0] run_reg, run_next;
  logic [6:0] dcnt_reg, dcnt_next;
  logic [CW-1:0] par_reg, par_next;
  logic [CW-1:0] sfield_reg, sfield_next;
  logic [CW-1:0] efield_reg, efield_next;
  logic [CW-1:0] chk_reg, chk_next;
  logic [CW-1:0] out_reg, out_next;
  logic outv_reg, outv_next, outsel_reg, outsel_next;
  logic [`BMRX_IRQ_W-1:0] ev;
  logic lose;

  // Software visible registers.
  logic [`BMRX_IRQ_W-1:0] istat_reg, istat_next, imask_reg, imask_next;
  logic [31:0] code0_reg, code0_next, code1_reg, code1_next;
  logic [31:0] rdata_reg, rdata_next;

  logic [CW-1:0] line_fill_char, message_open_char, message_close_char;
  logic [CW-1:0] block_open_char, block_close_char, tape_select_variant, answer_char;
  logic hw_framed, q_wr_valid, q_empty, q_full, q_rd_valid;
  logic [CW-1:0] q_wr_data, ch;
  logic sw_rehunt, rehunt, setup, access, mapped, is_framing, data_state;

  // Codes live in two registers so software can match any line code.
  assign line_fill_char = code0_reg[7:0];
  assign message_open_char = code0_reg[15:8];
  assign message_close_char = code0_reg[23:16];
  assign block_open_char = code0_reg[31:24];
  assign block_close_char = code1_reg[7:0];
  assign tape_select_variant = code1_reg[15:8];
  assign answer_char = code1_reg[23:16];

  // APB decode; the slave never waits, so pready is tied high by design.
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign pready = 1'b1;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= `BMRX_OFF_CODE1);
  assign pslverr = access && !mapped;
  assign sw_rehunt = access && pwrite && mapped && (paddr == `BMRX_OFF_CTRL) && pwdata[`BMRX_CTRL_REHUNT];
  assign rehunt = sw_rehunt || lose;

  bmrx_hunter u_hunter (
    .pclk(pclk),
    .presetn(presetn),
    .bit_in(rx_bit),
    .bit_valid(rx_bit_valid),
    .rehunt(rehunt),
    .line_fill_char(line_fill_char),
    .framed(hw_framed),
    .char_data(q_wr_data),
    .char_valid(q_wr_valid)
  );

  // The queue is drained whenever it holds a character, one per cycle at most.
  bmrx_fifo u_queue (
    .pclk(pclk),
    .presetn(presetn),
    .flush(rehunt),
    .wr_en(q_wr_valid),
    .wr_data(q_wr_data),
    .rd_en(!q_empty),
    .rd_data(ch),
    .rd_valid(q_rd_valid),
    .empty(q_empty),
    .full(q_full)
  );

  assign is_framing = (ch == message_open_char) || (ch == message_close_char) ||
                      (ch == block_open_char) || (ch == block_close_char);
  assign data_state = (state_reg == bmrx_pkg::st_sel) || (state_reg == bmrx_pkg::st_data) ||
                      (state_reg == bmrx_pkg::st_tail) || (state_reg == bmrx_pkg::st_check);

  // Character processing; a lost frame keeps the message flag and drops the data state.
  always_comb begin
    state_next = state_reg;
    msg_next = msg_reg;
    run_next = run_reg;
    dcnt_next = dcnt_reg;
    par_next = par_reg;
    sfield_next = sfield_reg;
    efield_next = efield_reg;
    chk_next = chk_reg;
    out_next = out_reg;
    outv_next = 1'b0;
    outsel_next = 1'b0;
    ev = '0;
    ev[`BMRX_EV_OVERFLOW] = q_wr_valid && q_full;
    lose = 1'b0;
    if (state_reg == bmrx_pkg::st_hunt) begin
      if (hw_framed) begin
        state_next = bmrx_pkg::st_confirm;
        run_next = 2'd0;
      end
    end else if (!hw_framed) begin
      state_next = bmrx_pkg::st_hunt;
    end else if (q_rd_valid) begin
      unique case (state_reg)
        bmrx_pkg::st_confirm: begin
          if (ch != line_fill_char) begin
            lose = 1'b1;
          end else if (run_reg == `BMRX_CONFIRM_FILLS - 2'd1) begin
            state_next = bmrx_pkg::st_idle;
            run_next = 2'd0;
            ev[`BMRX_EV_LOGICAL] = 1'b1;
          end else begin
            run_next = run_reg + 2'd1;
          end
        end
        bmrx_pkg::st_idle: begin
          if (ch == line_fill_char) begin
            run_next = 2'd0;
          end else if ((!msg_reg && ch == message_open_char) || (msg_reg && ch == block_open_char)) begin
            state_next = bmrx_pkg::st_sel;
            msg_next = 1'b1;
            run_next = 2'd0;
            dcnt_next = 7'd0;
            par_next = '0;
            efield_next = '0;
            sfield_next = '0;
            sfield_next[`BMRX_SF_MSG_OPEN] = (ch == message_open_char);
            sfield_next[`BMRX_SF_BLK_OPEN] = (ch == block_open_char);
            ev[`BMRX_EV_BLOCK_START] = 1'b1;
          end else if (run_reg == `BMRX_BAD_RUN - 2'd1) begin
            lose = 1'b1;
          end else begin
            run_next = run_reg + 2'd1;
          end
        end
        bmrx_pkg::st_sel: begin
          if (ch == answer_char) begin
            ev[`BMRX_EV_ANSWER] = 1'b1;
          end else begin
            sfield_next[`BMRX_SF_TAPE_SEL] = (ch == tape_select_variant);
            out_next = ch;
            outv_next = 1'b1;
            outsel_next = 1'b1;
            state_next = bmrx_pkg::st_data;
          end
        end
        bmrx_pkg::st_data: begin
          if (is_framing) begin
            lose = 1'b1;
          end else if (ch == answer_char) begin
            ev[`BMRX_EV_ANSWER] = 1'b1;
          end else begin
            // Translation to internal code is the identity here; the sum is a bitwise XOR.
            par_next = par_reg ^ ch;
            out_next = ch;
            outv_next = 1'b1;
            dcnt_next = dcnt_reg + 7'd1;
            if (dcnt_reg == `BMRX_DATA_LEN - 7'd1) begin
              state_next = bmrx_pkg::st_tail;
            end
          end
        end
        bmrx_pkg::st_tail: begin
          // Fills after the last data character are tolerated and not counted.
          if (ch == block_close_char) begin
            efield_next[`BMRX_EF_BLK_CLOSE] = 1'b1;
            state_next = bmrx_pkg::st_check;
          end else if (ch == message_close_char) begin
            efield_next[`BMRX_EF_MSG_CLOSE] = 1'b1;
            state_next = bmrx_pkg::st_check;
          end else if (ch != line_fill_char) begin
            lose = 1'b1;
          end
        end
        bmrx_pkg::st_check: begin
          chk_next = ch;
          state_next = bmrx_pkg::st_idle;
          if (ch == par_reg) begin
            ev[`BMRX_EV_CHECK_OK] = 1'b1;
            if (efield_reg[`BMRX_EF_MSG_CLOSE]) begin
              msg_next = 1'b0;
            end
          end else begin
            ev[`BMRX_EV_CHECK_ERR] = 1'b1;
          end
        end
        default: begin
          state_next = bmrx_pkg::st_hunt;
        end
      endcase
    end
    if (lose) begin
      state_next = bmrx_pkg::st_hunt;
      run_next = 2'd0;
      ev[`BMRX_EV_LOST] = 1'b1;
    end
  end

  // Processing state registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= bmrx_pkg::st_hunt;
      msg_reg <= 1'b0;
      run_reg <= 2'd0;
      dcnt_reg <= 7'd0;
      par_reg <= '0;
      sfield_reg <= '0;
      efield_reg <= '0;
      chk_reg <= '0;
      out_reg <= '0;
      outv_reg <= 1'b0;
      outsel_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      msg_reg <= msg_next;
      run_reg <= run_next;
      dcnt_reg <= dcnt_next;
      par_reg <= par_next;
      sfield_reg <= sfield_next;
      efield_reg <= efield_next;
      chk_reg <= chk_next;
      out_reg <= out_next;
      outv_reg <= outv_next;
      outsel_reg <= outsel_next;
    end
  end

  // Register writes and read data; read data is latched in the setup cycle.
  always_comb begin
    imask_next = imask_reg;
    code0_next = code0_reg;
    code1_next = code1_reg;
    rdata_next = rdata_reg;
    // A new event wins over the read that clears the status in the same cycle.
    istat_next = istat_reg | ev;
    if (access && !pwrite && paddr == `BMRX_OFF_IRQ_STAT) begin
      istat_next = ev;
    end
    if (access && pwrite) begin
      unique case (paddr)
        `BMRX_OFF_IRQ_MASK: imask_next = pwdata[`BMRX_IRQ_W-1:0];
        `BMRX_OFF_CODE0: code0_next = pwdata;
        `BMRX_OFF_CODE1: code1_next = {8'h00, pwdata[23:0]};
        default: begin
        end
      endcase
    end
    if (setup && !pwrite) begin
      unique case (paddr)
        `BMRX_OFF_STATUS: rdata_next = {26'h000_0000, (state_reg != bmrx_pkg::st_hunt &&
                                        state_reg != bmrx_pkg::st_confirm) ? run_reg : 2'd0,
                                        data_state, msg_reg,
                                        (state_reg != bmrx_pkg::st_hunt && state_reg != bmrx_pkg::st_confirm),
                                        hw_framed};
        `BMRX_OFF_IRQ_STAT: rdata_next = {25'h000_0000, istat_reg};
        `BMRX_OFF_IRQ_MASK: rdata_next = {25'h000_0000, imask_reg};
        `BMRX_OFF_FIELDS: rdata_next = {9'h000, dcnt_reg, efield_reg, sfield_reg};
        `BMRX_OFF_PARITY: rdata_next = {16'h0000, chk_reg, par_reg};
        `BMRX_OFF_CODE0: rdata_next = code0_reg;
        `BMRX_OFF_CODE1: rdata_next = code1_reg;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Software register storage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_reg <= '0;
      imask_reg <= '0;
      code0_reg <= {`BMRX_RST_BOPEN, `BMRX_RST_MCLOSE, `BMRX_RST_MOPEN, `BMRX_RST_FILL};
      code1_reg <= {8'h00, `BMRX_RST_ANSWER, `BMRX_RST_TAPE_SELECT_VARIANT, `BMRX_RST_BCLOSE};
      rdata_reg <= 32'h0000_0000;
    end else begin
      istat_reg <= istat_next;
      imask_reg <= imask_next;
      code0_reg <= code0_next;
      code1_reg <= code1_next;
      rdata_reg <= rdata_next;
    end
  end

  assign prdata = rdata_reg;
  assign irq = |(istat_reg & imask_reg);
  assign blk_char_data = out_reg;
  assign blk_char_valid = outv_reg;
  assign blk_char_is_sel = outsel_reg;

endmodule : bmrx_framer

// File: design/bmrx_hunter.sv
// Bit-level line unit that hunts for the line fill character and then frames characters.
`include "bmrx_consts.svh"

module bmrx_hunter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic bit_in,
  input wire logic bit_valid,
  input wire logic rehunt,
  input wire logic [`BMRX_CHAR_W-1:0] line_fill_char,
  output logic framed,
  output logic [`BMRX_CHAR_W-1:0] char_data,
  output logic char_valid
);

  logic [`BMRX_CHAR_W-1:0] shift_reg, shift_next, shifted;
  logic [2:0] bit_cnt_reg, bit_cnt_next;
  logic framed_reg, framed_next;
  logic [`BMRX_CHAR_W-1:0] char_reg, char_next;
  logic valid_reg, valid_next;

  // Bits arrive least significant first; while hunting every bit position is tried.
  always_comb begin
    shifted = {bit_in, shift_reg[`BMRX_CHAR_W-1:1]};
    shift_next = shift_reg;
    bit_cnt_next = bit_cnt_reg;
    framed_next = framed_reg;
    char_next = char_reg;
    valid_next = 1'b0;
    if (rehunt) begin
      shift_next = '0;
      bit_cnt_next = 3'd0;
      framed_next = 1'b0;
    end else if (bit_valid) begin
      shift_next = shifted;
      if (!framed_reg) begin
        // The matching fill itself is not forwarded, nothing is until it is seen.
        if (shifted == line_fill_char) begin
          framed_next = 1'b1;
          bit_cnt_next = 3'd0;
        end
      end else if (bit_cnt_reg == 3'd7) begin
        bit_cnt_next = 3'd0;
        char_next = shifted;
        valid_next = 1'b1;
      end else begin
        bit_cnt_next = bit_cnt_reg + 3'd1;
      end
    end
  end

  // Registers of the line unit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= '0;
      bit_cnt_reg <= 3'd0;
      framed_reg <= 1'b0;
      char_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      bit_cnt_reg <= bit_cnt_next;
      framed_reg <= framed_next;
      char_reg <= char_next;
      valid_reg <= valid_next;
    end
  end

  assign framed = framed_reg;
  assign char_data = char_reg;
  assign char_valid = valid_reg;

endmodule : bmrx_hunter

// File: design/bmrx_pkg.sv
// Types shared by the block message receive framer.
package bmrx_pkg;

  // Receive processing states.
  typedef enum logic [2:0] {
    st_hunt,
    st_confirm,
    st_idle,
    st_sel,
    st_data,
    st_tail,
    st_check
  } bmrx_state_t;

endpackage : bmrx_pkg
